// file: hdl/srct_pkg.sv
// constants and types for the system reset countdown timer
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - the countdown decrements from the loaded value and raises a system reset request at zero.
// - a reload before expiry restarts the countdown from the new value.
// - configuration goes through an index port holding the register number and a data port.
// - unlock is the unlock byte twice on the index port, then select 07h, then enable 01h.
// - time base register value 71h selects seconds and 79h selects minutes.
// - a count of zero disables the timeout, nonzero n expires after n time-base units.
// - the largest count 255 gives 255 units in either time base.
//////////////////////////////////////////////////////////////////////////////
package srct_pkg;

  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned SEC_S           = 1;
  localparam int unsigned SEC_CYCLES      = CLK_HZ * SEC_S;
  localparam int unsigned MIN_SECONDS     = 60;

  // port addresses: index port and data port
  localparam logic [7:0]  PORT_INDEX      = 8'h2e;
  localparam logic [7:0]  PORT_DATA       = 8'h2f;
  localparam logic [7:0]  UNLOCK_KEY      = 8'h87;
  localparam logic [7:0]  LOCK_KEY        = 8'haa;

  // register offsets
  localparam logic [7:0]  REG_DEV_SEL     = 8'h07;
  localparam logic [7:0]  REG_DEV_EN      = 8'h30;
  localparam logic [7:0]  REG_ACT_CTRL    = 8'hf0;
  localparam logic [7:0]  REG_TIME_BASE   = 8'hf5;
  localparam logic [7:0]  REG_COUNT       = 8'hf6;

  localparam logic [7:0]  GUARD_DEVICE    = 8'h07;
  localparam int unsigned ENABLE_BIT      = 0;
  localparam int unsigned ACTIVE_BIT      = 7;
  localparam logic [7:0]  BASE_SECONDS    = 8'h71;
  localparam logic [7:0]  BASE_MINUTES    = 8'h79;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;
  localparam logic [7:0]  IDLE_READ       = 8'hff;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } srct_io_req_t;

  typedef enum logic [1:0] {
    SRCT_LOCKED,
    SRCT_HALF,
    SRCT_OPEN
  } srct_lock_t;

endpackage

// file: hdl/srct_countdown_guard.sv
// countdown guard with index/data configuration port
`timescale 1ns/1ps
module srct_countdown_guard #(
  parameter int unsigned SEC_CYCLES_P  = srct_pkg::SEC_CYCLES,
  parameter int unsigned MIN_SECONDS_P = srct_pkg::MIN_SECONDS
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire srct_pkg::srct_io_req_t io_req,
  output logic [7:0]                  io_rdata,
  output logic                        reset_request
);
  import srct_pkg::*;

  // minute units at the full clock rate need more than 32 bits of cycles
  localparam int unsigned TICK_W = 40;

  function automatic logic is_port(input logic [7:0] a, input logic [7:0] p);
    return a == p;
  endfunction

  // registers past the device select answer only while the guard is selected
  function automatic logic guard_reg(input logic [7:0] idx,
                                     input logic [7:0] r,
                                     input logic       sel);
    return sel && idx == r;
  endfunction

  srct_lock_t        lock_state,  next_lock_state;
  logic [7:0]        index,       next_index;
  logic [7:0]        dev_sel,     next_dev_sel;
  logic [7:0]        dev_en,      next_dev_en;
  logic [7:0]        act_ctrl,    next_act_ctrl;
  logic [7:0]        time_base,   next_time_base;
  logic [7:0]        count,       next_count;
  logic [TICK_W-1:0] tick_cnt,    next_tick_cnt;
  logic              expired,     next_expired;
  logic [7:0]        rdata_q,     next_rdata;
  logic              guard_sel;
  logic              running;
  logic              idx_wr;
  logic              dat_wr;
  logic              dat_rd;
  logic              hit_dev_sel;
  logic              hit_dev_en;
  logic              hit_act;
  logic              hit_base;
  logic              hit_count;
  logic              count_wr;
  logic              tick_done;
  logic [TICK_W-1:0] tick_limit;

  ////////////////////////////////////////////////////////////////////////////
  // port strobes and register decode
  always_comb begin
    idx_wr      = io_req.wr && is_port(io_req.addr, PORT_INDEX);
    dat_wr      = io_req.wr && is_port(io_req.addr, PORT_DATA) && lock_state == SRCT_OPEN;
    dat_rd      = io_req.rd && is_port(io_req.addr, PORT_DATA) && lock_state == SRCT_OPEN;
    guard_sel   = dev_sel == GUARD_DEVICE;
    hit_dev_sel = index == REG_DEV_SEL;
    hit_dev_en  = guard_reg(index, REG_DEV_EN, guard_sel);
    hit_act     = guard_reg(index, REG_ACT_CTRL, guard_sel);
    hit_base    = guard_reg(index, REG_TIME_BASE, guard_sel);
    hit_count   = guard_reg(index, REG_COUNT, guard_sel);
    count_wr    = dat_wr && hit_count;
  end

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence and index register
  always_comb begin
    next_lock_state = lock_state;
    next_index      = index;
    // unlock needs two back to back key writes to the index port
    case (lock_state)
      SRCT_LOCKED: begin
        if (idx_wr && io_req.wdata == UNLOCK_KEY) begin
          next_lock_state = SRCT_HALF;
        end
      end
      SRCT_HALF: begin
        if (idx_wr) begin
          next_lock_state = (io_req.wdata == UNLOCK_KEY) ? SRCT_OPEN : SRCT_LOCKED;
        end
      end
      default: begin
        if (idx_wr && io_req.wdata == LOCK_KEY) begin
          next_lock_state = SRCT_LOCKED;
        end else if (idx_wr) begin
          next_index = io_req.wdata;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_state <= SRCT_LOCKED;
      index      <= ZERO_BYTE;
    end else begin
      lock_state <= next_lock_state;
      index      <= next_index;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers; writes while locked never get here
  always_comb begin
    next_dev_sel   = dev_sel;
    next_dev_en    = dev_en;
    next_act_ctrl  = act_ctrl;
    next_time_base = time_base;
    if (dat_wr) begin
      if (hit_dev_sel) begin
        next_dev_sel = io_req.wdata;
      end else if (hit_dev_en) begin
        next_dev_en = io_req.wdata;
      end else if (hit_act) begin
        next_act_ctrl = io_req.wdata;
      end else if (hit_base) begin
        next_time_base = io_req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dev_sel   <= ZERO_BYTE;
      dev_en    <= ZERO_BYTE;
      act_ctrl  <= ZERO_BYTE;
      time_base <= BASE_SECONDS;
    end else begin
      dev_sel   <= next_dev_sel;
      dev_en    <= next_dev_en;
      act_ctrl  <= next_act_ctrl;
      time_base <= next_time_base;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back; data stands one cycle, locked or unmapped reads give all ones
  always_comb begin
    next_rdata = IDLE_READ;
    if (dat_rd) begin
      if (hit_dev_sel) begin
        next_rdata = dev_sel;
      end else if (hit_dev_en) begin
        next_rdata = dev_en;
      end else if (hit_act) begin
        next_rdata = act_ctrl;
      end else if (hit_base) begin
        next_rdata = time_base;
      end else if (hit_count) begin
        next_rdata = count;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= IDLE_READ;
    end else begin
      rdata_q <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unit divider; clearing enable or activation pauses, it does not restart
  always_comb begin
    running    = dev_en[ENABLE_BIT] && act_ctrl[ACTIVE_BIT];
    // any value other than the minute code counts seconds
    tick_limit = (time_base == BASE_MINUTES) ?
                 TICK_W'(SEC_CYCLES_P) * TICK_W'(MIN_SECONDS_P) :
                 TICK_W'(SEC_CYCLES_P);
    tick_done  = tick_cnt == tick_limit - TICK_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // countdown; count register doubles as remaining units (reads back live)
  always_comb begin
    next_count    = count;
    next_tick_cnt = tick_cnt;
    next_expired  = expired;
    // a reload wins over a decrement falling in the same cycle
    if (count_wr) begin
      next_count    = io_req.wdata;
      next_tick_cnt = '0;
      next_expired  = 1'b0;
    end else if (running && count != ZERO_BYTE) begin
      if (tick_done) begin
        next_tick_cnt = '0;
        next_count    = count - 8'h01;
        if (count == 8'h01) begin
          next_expired = 1'b1;
        end
      end else begin
        next_tick_cnt = tick_cnt + TICK_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count    <= ZERO_BYTE;
      tick_cnt <= '0;
      expired  <= 1'b0;
    end else begin
      count    <= next_count;
      tick_cnt <= next_tick_cnt;
      expired  <= next_expired;
    end
  end

  assign io_rdata      = rdata_q;
  // request holds until a count write or the system reset clears it
  assign reset_request = expired;

endmodule

// file: sim/srct_guard_asserts.sv
// port assertions for the countdown guard
`timescale 1ns/1ps
module srct_guard_asserts #(
  parameter int unsigned SEC_CYCLES_P  = 10,
  parameter int unsigned MIN_SECONDS_P = 3
) (
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire srct_pkg::srct_io_req_t io_req,
  input wire logic [7:0]             io_rdata,
  input wire logic                   reset_request
);
  import srct_pkg::*;
  //////////////////////////////////////////
  logic [1:0] keys, next_keys;
  logic [7:0] idx, next_idx, sel, next_sel;
  wire ix = io_req.wr && io_req.addr == PORT_INDEX;
  wire dw = io_req.wr && io_req.addr == PORT_DATA && keys == 2'd2;
  wire cw = dw && idx == REG_COUNT && sel == GUARD_DEVICE;
  // shadow of unlock state, index and device select
  always_comb begin
    next_keys = keys;
    next_idx  = idx;
    next_sel  = sel;
    if (ix && keys != 2'd2) next_keys = (io_req.wdata == UNLOCK_KEY) ? keys + 2'd1 : 2'd0;
    if (ix && keys == 2'd2) next_keys = (io_req.wdata == LOCK_KEY) ? 2'd0 : 2'd2;
    if (ix && keys == 2'd2 && io_req.wdata != LOCK_KEY) next_idx = io_req.wdata;
    if (dw && idx == REG_DEV_SEL) next_sel = io_req.wdata;
  end
  always_ff @(posedge clk) begin
    keys <= sys_rst ? 2'd0 : next_keys;
    idx  <= sys_rst ? 8'h00 : next_idx;
    sel  <= sys_rst ? 8'h00 : next_sel;
  end
  //////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rd_idle; !$past(io_req.rd) |-> io_rdata == IDLE_READ; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_nomap; $past(io_req.rd && io_req.addr > PORT_DATA) |-> io_rdata == IDLE_READ;
  endproperty
  a_rd_nomap: assert property (p_rd_nomap) else $error("unmapped read answered");
  property p_locked; $past(io_req.rd && io_req.addr == PORT_DATA && keys != 2'd2)
    |-> io_rdata == IDLE_READ; endproperty
  a_locked: assert property (p_locked) else $error("locked read answered");
  property p_sel_off; $past(io_req.rd && io_req.addr == PORT_DATA && idx == REG_COUNT
    && sel != GUARD_DEVICE) |-> io_rdata == IDLE_READ; endproperty
  a_sel_off: assert property (p_sel_off) else $error("unselected read answered");
  property p_rq_hold; reset_request && !io_req.wr |=> reset_request; endproperty
  a_rq_hold: assert property (p_rq_hold) else $error("reset request dropped");
  property p_rq_init; $fell(sys_rst) |-> !reset_request; endproperty
  a_rq_init: assert property (p_rq_init) else $error("reset request after reset");
  property p_reload; cw |=> !reset_request; endproperty
  a_reload: assert property (p_reload) else $error("reload kept request");
  // a count write of zero keeps the request low for the next eight cycles
  property p_zero; cw && io_req.wdata == ZERO_BYTE |=> !reset_request [*8]; endproperty
  a_zero: assert property (p_zero) else $error("zero count expired");
endmodule
bind srct_countdown_guard srct_guard_asserts #(
  .SEC_CYCLES_P (SEC_CYCLES_P),
  .MIN_SECONDS_P(MIN_SECONDS_P)
) u_chk (
  .clk          (clk),
  .sys_rst      (sys_rst),
  .io_req       (io_req),
  .io_rdata     (io_rdata),
  .reset_request(reset_request)
);

// file: sim/srct_host_model.sv
// host model issuing index/data port cycles
`timescale 1ns/1ps
module srct_host_model (
  input  wire logic                   clk,
  output srct_pkg::srct_io_req_t      req,
  input  wire logic [7:0]             rdata
);
  import srct_pkg::*;
  initial req = '0;
  // released lines show inverted values so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    // read data stands only in the cycle after the strobe edge
    d = rdata;
    req = '{1'b0, 1'b0, ~a, 8'hff};
  endtask
endmodule

// file: sim/test_system_reset_countdown_timer.sv
// bench for the countdown guard
`timescale 1ns/1ps
module test_system_reset_countdown_timer;
  import srct_pkg::*;
  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  srct_io_req_t io_req;
  logic [7:0]   io_rdata, d;
  logic         reset_request;
  int           n_fail = 0, n_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  srct_host_model u_host (.clk(clk), .req(io_req), .rdata(io_rdata));
  // short units: 10 cycles a second, 3 seconds a minute
  srct_countdown_guard #(.SEC_CYCLES_P(10), .MIN_SECONDS_P(3)) u_dut (.clk(clk),
    .sys_rst(sys_rst), .io_req(io_req), .io_rdata(io_rdata), .reset_request(reset_request));
  //////////////////////////////////////////
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wreg(input logic [7:0] r, input logic [7:0] v);
    u_host.wr(PORT_INDEX, r);
    u_host.wr(PORT_DATA, v);
  endtask
  task rreg(input logic [7:0] r, input logic [7:0] e);
    u_host.wr(PORT_INDEX, r);
    u_host.rd(PORT_DATA, d);
    chk(d, e);
  endtask
  // low until t-3 cycles, high by t+3: phase slack of the unit divider
  task expire(input int t);
    for (int i = 0; i < t + 3; i++) begin
      @(negedge clk);
      if (i < t - 3) chk({7'h0, reset_request}, 8'h00);
    end
    chk({7'h0, reset_request}, 8'h01);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test;
    end
  end
  //////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    rreg(REG_COUNT, IDLE_READ);
    u_host.wr(PORT_INDEX, UNLOCK_KEY);
    u_host.wr(PORT_INDEX, UNLOCK_KEY);
    wreg(REG_DEV_SEL, GUARD_DEVICE);
    wreg(REG_DEV_EN, 8'h01);
    wreg(REG_ACT_CTRL, 8'h80);
    rreg(REG_TIME_BASE, BASE_SECONDS);
    wreg(REG_COUNT, 8'hff);
    rreg(REG_COUNT, 8'hff);
    wreg(REG_COUNT, ZERO_BYTE);
    repeat (600) @(negedge clk);
    chk({7'h0, reset_request}, 8'h00);
    wreg(REG_COUNT, 8'h04);
    expire(40);
    wreg(REG_COUNT, 8'h03);
    chk({7'h0, reset_request}, 8'h00);
    repeat (20) @(negedge clk);
    wreg(REG_COUNT, 8'h03);
    expire(30);
    wreg(REG_TIME_BASE, BASE_MINUTES);
    wreg(REG_COUNT, 8'h02);
    expire(60);
    u_host.rd(8'h30, d);
    chk(d, IDLE_READ);
    rreg(REG_DEV_SEL, GUARD_DEVICE);
    wreg(REG_DEV_SEL, ZERO_BYTE);
    rreg(REG_COUNT, IDLE_READ);
    wreg(REG_DEV_SEL, GUARD_DEVICE);
    rreg(REG_TIME_BASE, BASE_MINUTES);
    u_host.wr(PORT_INDEX, LOCK_KEY);
    rreg(REG_DEV_SEL, IDLE_READ);
    end_of_test;
  end
endmodule
